// file: pkg/flash_regs_pkg.sv
package flash_regs_pkg;

  // ********************************
  // Register indices (byte address = 4 * index)
  // ********************************
  localparam logic [5:0] STATUS_IDX = 6'h00;
  localparam logic [5:0] CMD_INDEX_IDX = 6'h01;
  localparam logic [5:0] EEPROT_IDX = 6'h09;
  localparam logic [5:0] OPTION_IDX = 6'h0A;
  localparam logic [5:0] RSV_TEST_IDX = 6'h0B;
  localparam logic [5:0] CMD_WORD0_IDX = 6'h10;
  localparam int NUM_CMD_WORDS = 6;

  // ********************************
  // Field positions
  // ********************************
  localparam int COMMAND_COMPLETE_FLAG_BIT = 7;
  localparam int ACCESS_ERROR_FLAG_BIT = 5;
  localparam int PROTECTION_VIOLATION_FLAG_BIT = 4;
  localparam int PROT_OPEN_BIT = 7;
  localparam int PROT_SIZE_LSB = 0;
  localparam int BYTE_LO = 0;
  localparam int BYTE_HI = 1;

  // ********************************
  // Reset and fault values
  // ********************************
  localparam logic PROT_OPEN_FAULT = 1'b0;
  localparam logic [1:0] PROT_SIZE_FAULT = 2'h3;
  localparam logic [7:0] OPTION_FAULT = 8'hFF;
  localparam logic [2:0] CMD_INDEX_RESET = 3'h0;

  // ********************************
  // EEPROM protection geometry
  // ********************************
  localparam logic [23:0] EE_BASE = 24'h10_0000;
  localparam logic [23:0] EE_SECTOR_BYTES = 24'h00_0020;

  // ********************************
  // AHB encodings
  // ********************************
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;

  typedef enum logic [1:0] {PH_IDLE, PH_WR, PH_RD_WAIT} bus_phase_t;

endpackage

// file: rtl/eeprom_guard.sv
`timescale 1ns/100ps
module eeprom_guard
  import flash_regs_pkg::*;
(
  input wire logic prot_open,
  input wire logic [1:0] prot_size,
  input wire logic [23:0] op_addr,
  input wire logic op_block_erase,
  output logic violation
);

  logic [23:0] limit;
  logic in_range;

  // Protected window grows from the base in 32-byte steps
  assign limit = EE_BASE + ({22'h0, prot_size} + 24'h1) * EE_SECTOR_BYTES;
  assign in_range = (op_addr >= EE_BASE) && (op_addr < limit);

  // With open set the size is ignored; block erase needs no sector protected
  always_comb begin
    if (prot_open) begin
      violation = 1'b0;
    end else if (op_block_erase) begin
      violation = 1'b1;
    end else begin
      violation = in_range;
    end
  end

endmodule

// file: rtl/flash_protect_cmd_regs.sv
// Our own choice: the AHB-Lite register port.
`timescale 1ns/100ps
// Operation
// - Normal mode: size may only grow
// - Normal mode: open bit only 1 to 0
// - Open bit set makes size irrelevant
// - Special mode: protection fields freely writable
// - Reset loads protection from configuration byte
// - Double fault: open cleared, size maximal
// - Protected program/erase refused, violation flag set
// - Whole block erase refused if protected
// - Open bit 0 protects, 1 unprotects
// - Size selects 32, 64, 96, 128 bytes
// - Option register readable, writes ignored
// - Reset loads option bits from configuration
// - Double fault sets all option bits
// - Reserved test register reads zero, ignores writes
// - Six command words, byte-wide half access
// - Writing 1 to complete flag launches
// - Command words locked until completion
// - Results written back into command words
// - Word layout: code, address, four data
// - Flag clear: command word writes ignored
module flash_protect_cmd_regs
  import flash_regs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic special_mode_pin,
  input wire logic cfg_ready,
  input wire logic [7:0] cfg_prot_byte,
  input wire logic cfg_prot_fault,
  input wire logic [7:0] cfg_option_byte,
  input wire logic cfg_option_fault,
  output logic cfg_loaded,
  output logic cmd_launch,
  output logic [95:0] command_object_array,
  output logic [2:0] command_word_index,
  input wire logic cmd_done,
  input wire logic result_we,
  input wire logic [2:0] result_index,
  input wire logic [15:0] result_data,
  input wire logic access_error_set,
  input wire logic op_check,
  input wire logic [23:0] op_addr,
  input wire logic op_block_erase,
  output logic op_refused,
  output logic eeprom_prot_open,
  output logic [1:0] eeprom_prot_size,
  output logic [7:0] nonvolatile_option_bits
);

  // ********************************
  // Reset release and mode pin
  // ********************************
  logic rst_meta_n;
  logic rst_sync_n;
  logic mode_meta;
  logic special_mode;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_meta <= 1'b0;
      special_mode <= 1'b0;
    end else begin
      mode_meta <= special_mode_pin;
      special_mode <= mode_meta;
    end
  end

  // ********************************
  // AHB-Lite slave
  // ********************************
  // Reads take one wait state so read data always comes from a flop
  bus_phase_t phase;
  bus_phase_t next_phase;
  logic [5:0] addr_idx;
  logic [5:0] next_addr_idx;
  logic [1:0] addr_be;
  logic [1:0] next_addr_be;
  logic [31:0] next_hrdata;
  logic next_hreadyout;
  logic [31:0] rd_value;
  logic [1:0] be;
  logic wr_go;

  logic command_complete_flag;
  logic access_error_flag;
  logic protection_violation_flag;
  logic [15:0] cmd_word [NUM_CMD_WORDS];

  assign wr_go = (phase == PH_WR);

  always_comb begin
    be = 2'b11;
    if (hsize == HSIZE_BYTE) begin
      be = (haddr[1:0] == 2'h0) ? 2'b01 : (haddr[1:0] == 2'h1) ? 2'b10 : 2'b00;
    end else if (hsize == HSIZE_HALF && haddr[1]) begin
      be = 2'b00;
    end
  end

  always_comb begin
    rd_value = 32'h0;
    case (addr_idx)
      STATUS_IDX: begin
        rd_value[COMMAND_COMPLETE_FLAG_BIT] = command_complete_flag;
        rd_value[ACCESS_ERROR_FLAG_BIT] = access_error_flag;
        rd_value[PROTECTION_VIOLATION_FLAG_BIT] = protection_violation_flag;
      end
      CMD_INDEX_IDX: rd_value[2:0] = command_word_index;
      EEPROT_IDX: begin
        rd_value[PROT_OPEN_BIT] = eeprom_prot_open;
        rd_value[PROT_SIZE_LSB +: 2] = eeprom_prot_size;
      end
      OPTION_IDX: rd_value[7:0] = nonvolatile_option_bits;
      RSV_TEST_IDX: rd_value = 32'h0;
      default: begin
        for (int i = 0; i < NUM_CMD_WORDS; i++) begin
          if (addr_idx == CMD_WORD0_IDX + 6'(i)) begin
            rd_value[15:0] = cmd_word[i];
          end
        end
      end
    endcase
  end

  always_comb begin
    next_phase = PH_IDLE;
    next_addr_idx = addr_idx;
    next_addr_be = addr_be;
    next_hrdata = hrdata;
    next_hreadyout = 1'b1;
    if (phase == PH_RD_WAIT) begin
      next_hrdata = rd_value;
    end else if (hsel && htrans[1] && hready) begin
      next_addr_idx = haddr[7:2];
      next_addr_be = (haddr[31:8] == 24'h0) ? be : 2'b00;
      next_phase = hwrite ? PH_WR : PH_RD_WAIT;
      next_hreadyout = hwrite;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase <= PH_IDLE;
      addr_idx <= 6'h0;
      addr_be <= 2'b00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      phase <= next_phase;
      addr_idx <= next_addr_idx;
      addr_be <= next_addr_be;
      hrdata <= next_hrdata;
      hreadyout <= next_hreadyout;
      // Every transfer is answered OKAY; kept in a flop like the other outputs
      hresp <= 1'b0;
    end
  end

  // ********************************
  // Protection, option, command words
  // ********************************
  logic violation;
  logic next_command_complete_flag;
  logic next_access_error_flag;
  logic next_protection_violation_flag;
  logic next_open;
  logic [1:0] next_size;
  logic [7:0] next_option;
  logic next_loaded;
  logic next_launch;
  logic next_refused;
  logic [2:0] next_index;
  logic [15:0] next_word [NUM_CMD_WORDS];

  eeprom_guard guard (
    .prot_open(eeprom_prot_open),
    .prot_size(eeprom_prot_size),
    .op_addr(op_addr),
    .op_block_erase(op_block_erase),
    .violation(violation)
  );

  always_comb begin
    next_command_complete_flag = command_complete_flag;
    next_access_error_flag = access_error_flag;
    next_protection_violation_flag = protection_violation_flag;
    next_open = eeprom_prot_open;
    next_size = eeprom_prot_size;
    next_option = nonvolatile_option_bits;
    next_loaded = cfg_loaded;
    next_launch = 1'b0;
    next_refused = 1'b0;
    next_index = command_word_index;
    next_word = cmd_word;
    if (wr_go) begin
      case (addr_idx)
        STATUS_IDX: if (addr_be[BYTE_LO]) begin
          if (hwdata[COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag) begin
            next_command_complete_flag = 1'b0;
            next_launch = 1'b1;
          end
          if (hwdata[ACCESS_ERROR_FLAG_BIT]) next_access_error_flag = 1'b0;
          if (hwdata[PROTECTION_VIOLATION_FLAG_BIT]) next_protection_violation_flag = 1'b0;
        end
        CMD_INDEX_IDX: if (addr_be[BYTE_LO] && command_complete_flag) begin
          next_index = hwdata[2:0];
        end
        EEPROT_IDX: if (addr_be[BYTE_LO]) begin
          if (special_mode) begin
            next_open = hwdata[PROT_OPEN_BIT];
            next_size = hwdata[PROT_SIZE_LSB +: 2];
          end else begin
            if (!hwdata[PROT_OPEN_BIT]) next_open = 1'b0;
            if (hwdata[PROT_SIZE_LSB +: 2] > eeprom_prot_size) begin
              next_size = hwdata[PROT_SIZE_LSB +: 2];
            end
          end
        end
        default: begin
          for (int i = 0; i < NUM_CMD_WORDS; i++) begin
            // Locked while a command runs
            if (addr_idx == CMD_WORD0_IDX + 6'(i) && command_complete_flag) begin
              if (addr_be[BYTE_LO]) next_word[i][7:0] = hwdata[7:0];
              if (addr_be[BYTE_HI]) next_word[i][15:8] = hwdata[15:8];
            end
          end
        end
      endcase
    end
    if (!command_complete_flag && result_we && result_index < 3'(NUM_CMD_WORDS)) begin
      next_word[result_index] = result_data;
    end
    if (!command_complete_flag && cmd_done) next_command_complete_flag = 1'b1;
    // Hardware sets are applied last so they win over a same-cycle clear
    if (op_check && violation) begin
      next_protection_violation_flag = 1'b1;
      next_refused = 1'b1;
    end
    if (access_error_set) next_access_error_flag = 1'b1;
    // Configuration load takes priority over any early software write
    if (!cfg_loaded && cfg_ready) begin
      next_loaded = 1'b1;
      next_open = cfg_prot_fault ? PROT_OPEN_FAULT : cfg_prot_byte[PROT_OPEN_BIT];
      next_size = cfg_prot_fault ? PROT_SIZE_FAULT : cfg_prot_byte[PROT_SIZE_LSB +: 2];
      next_option = cfg_option_fault ? OPTION_FAULT : cfg_option_byte;
    end
  end

  // Until loaded the safe values hold in normal mode: fully protected, options all set
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      command_complete_flag <= 1'b1;
      access_error_flag <= 1'b0;
      protection_violation_flag <= 1'b0;
      eeprom_prot_open <= PROT_OPEN_FAULT;
      eeprom_prot_size <= PROT_SIZE_FAULT;
      nonvolatile_option_bits <= OPTION_FAULT;
      cfg_loaded <= 1'b0;
      cmd_launch <= 1'b0;
      op_refused <= 1'b0;
      command_word_index <= CMD_INDEX_RESET;
      for (int i = 0; i < NUM_CMD_WORDS; i++) begin
        cmd_word[i] <= 16'h0000;
      end
    end else begin
      command_complete_flag <= next_command_complete_flag;
      access_error_flag <= next_access_error_flag;
      protection_violation_flag <= next_protection_violation_flag;
      eeprom_prot_open <= next_open;
      eeprom_prot_size <= next_size;
      nonvolatile_option_bits <= next_option;
      cfg_loaded <= next_loaded;
      cmd_launch <= next_launch;
      op_refused <= next_refused;
      command_word_index <= next_index;
      cmd_word <= next_word;
    end
  end

  // Word 0 high byte is the command code, word 1 the low address
  genvar g;
  generate
    for (g = 0; g < NUM_CMD_WORDS; g++) begin : g_words
      assign command_object_array[16*g +: 16] = cmd_word[g];
    end
  endgenerate

  // ********************************
  // Checks
  // ********************************
  logic ee_wr;
  assign ee_wr = wr_go && addr_idx == EEPROT_IDX && addr_be[BYTE_LO] && cfg_loaded;

  size_grow_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    ee_wr && !special_mode && hwdata[1:0] <= eeprom_prot_size |=> $stable(eeprom_prot_size))
    else $error("protection size shrank in normal mode");

  open_close_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    cfg_loaded && !special_mode && !eeprom_prot_open |=> !eeprom_prot_open)
    else $error("open bit reopened in normal mode");

  open_ignore_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    op_check && eeprom_prot_open |=> !op_refused)
    else $error("operation refused while protection open");

  special_write_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    ee_wr && special_mode |=> eeprom_prot_open == $past(hwdata[7])
      && eeprom_prot_size == $past(hwdata[1:0]))
    else $error("special mode protection write not taken");

  prot_fault_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !cfg_loaded && cfg_ready && cfg_prot_fault |=> !eeprom_prot_open
      && eeprom_prot_size == 2'h3 && cfg_loaded)
    else $error("protection fault load not fully protected");

  opt_fault_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !cfg_loaded && cfg_ready && cfg_option_fault |=> nonvolatile_option_bits == 8'hFF)
    else $error("option fault load not all ones");

  viol_flag_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    op_check && !eeprom_prot_open && !op_block_erase && op_addr >= EE_BASE
      && op_addr < EE_BASE + EE_SECTOR_BYTES
      |=> op_refused && protection_violation_flag)
    else $error("protected access not refused");

  block_erase_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    op_check && op_block_erase && !eeprom_prot_open |=> op_refused)
    else $error("block erase with protection not refused");

  launch_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    wr_go && addr_idx == STATUS_IDX && addr_be[0] && hwdata[7] && command_complete_flag
      |=> !command_complete_flag && cmd_launch ##1 !cmd_launch)
    else $error("launch write did not start a command");

  word_lock_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !command_complete_flag && !result_we |=> $stable(command_object_array))
    else $error("command words changed while locked");

  rsv_zero_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
    phase == PH_RD_WAIT && addr_idx == RSV_TEST_IDX |=> hrdata == 32'h0 && hreadyout)
    else $error("reserved register read nonzero");

endmodule

// file: bench/flash_protect_cmd_regs_tb.sv
`timescale 1ns/100ps
module flash_protect_cmd_regs_tb;
  import flash_regs_pkg::*;

  typedef struct {logic [5:0] idx; logic [31:0] wdata; logic [31:0] exp;} row_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, special_mode_pin = 1'b0, cfg_ready = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] cfg_prot_byte = 8'h80, cfg_option_byte = 8'h5A;
  logic cfg_prot_fault = 1'b0, cfg_option_fault = 1'b0, cmd_done = 1'b0, result_we = 1'b0;
  logic [2:0] result_index = 3'h0;
  logic [15:0] result_data = 16'h0;
  logic access_error_set = 1'b0, op_check = 1'b0, op_block_erase = 1'b0;
  logic [23:0] op_addr = 24'h0;
  wire logic hready;
  logic [31:0] hrdata;
  logic hreadyout, hresp, cfg_loaded, cmd_launch, op_refused, eeprom_prot_open;
  logic [95:0] command_object_array;
  logic [2:0] command_word_index;
  logic [1:0] eeprom_prot_size;
  logic [7:0] nonvolatile_option_bits;
  int fail_count = 0;
  int samples_checked = 0;
  int launches = 0;
  logic [31:0] rd;
  row_t rows [8];

  assign hready = hreadyout;

  flash_protect_cmd_regs DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .special_mode_pin(special_mode_pin), .cfg_ready(cfg_ready),
    .cfg_prot_byte(cfg_prot_byte), .cfg_prot_fault(cfg_prot_fault),
    .cfg_option_byte(cfg_option_byte), .cfg_option_fault(cfg_option_fault),
    .cfg_loaded(cfg_loaded), .cmd_launch(cmd_launch),
    .command_object_array(command_object_array), .command_word_index(command_word_index),
    .cmd_done(cmd_done), .result_we(result_we), .result_index(result_index),
    .result_data(result_data), .access_error_set(access_error_set), .op_check(op_check),
    .op_addr(op_addr), .op_block_erase(op_block_erase), .op_refused(op_refused),
    .eeprom_prot_open(eeprom_prot_open), .eeprom_prot_size(eeprom_prot_size),
    .nonvolatile_option_bits(nonvolatile_option_bits));

  initial begin
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cmd_launch === 1'b1) launches <= launches + 1;
  end

  // ********************************
  // Bus and check helpers
  // ********************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One AHB single transfer; waits on hready in both phases
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= sz;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, {24'h0, idx, 2'b00}, 3'h2, d, r);
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, {24'h0, idx, 2'b00}, 3'h2, 32'h0, r);
    check(r & mask, exp, "register read");
    check({31'h0, hresp}, 32'h0, "okay response");
  endtask

  task automatic op(input logic [23:0] a, input logic be, input logic exp);
    @(posedge clk);
    op_check <= 1'b1;
    op_addr <= a;
    op_block_erase <= be;
    @(posedge clk);
    op_check <= 1'b0;
    #1;
    check({31'h0, op_refused}, {31'h0, exp}, "op refused");
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    check({20'h0, eeprom_prot_open, eeprom_prot_size, nonvolatile_option_bits, cfg_loaded},
          {20'h0, PROT_OPEN_FAULT, PROT_SIZE_FAULT, OPTION_FAULT, 1'b0}, "in reset");
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    cfg_ready <= 1'b1;
    @(posedge clk);
    cfg_ready <= 1'b0;
    repeat (2) @(posedge clk);
    check({31'h0, cfg_loaded}, 32'h1, "config loaded");
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge clk);
    fail_count++;
    results();
  end

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    rows[0] = '{EEPROT_IDX, 32'h81, 32'h81};
    rows[1] = '{EEPROT_IDX, 32'h80, 32'h81};
    rows[2] = '{EEPROT_IDX, 32'h01, 32'h01};
    rows[3] = '{EEPROT_IDX, 32'h81, 32'h01};
    rows[4] = '{EEPROT_IDX, 32'h7E, 32'h02};
    rows[5] = '{OPTION_IDX, 32'h00, 32'h5A};
    rows[6] = '{RSV_TEST_IDX, 32'hFF, 32'h00};
    rows[7] = '{6'h3F, 32'hFF, 32'h00};
    do_reset();
    rdc(EEPROT_IDX, 32'hFFFFFFFF, 32'h80);
    rdc(OPTION_IDX, 32'hFFFFFFFF, 32'h5A);
    check({24'h0, nonvolatile_option_bits}, 32'h5A, "option port");
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wdata);
      rdc(rows[i].idx, 32'hFFFFFFFF, rows[i].exp);
    end
    op(EE_BASE + 24'h5F, 1'b0, 1'b1);
    op(EE_BASE + 24'h60, 1'b0, 1'b0);
    op(EE_BASE - 24'h1, 1'b0, 1'b0);
    op(EE_BASE + 24'h70, 1'b1, 1'b1);
    rdc(STATUS_IDX, 32'h10, 32'h10);
    wr(STATUS_IDX, 32'h10);
    rdc(STATUS_IDX, 32'h10, 32'h00);
    @(posedge clk) access_error_set <= 1'b1;
    @(posedge clk) access_error_set <= 1'b0;
    rdc(STATUS_IDX, 32'h20, 32'h20);
    wr(STATUS_IDX, 32'h20);
    rdc(STATUS_IDX, 32'hB0, 32'h80);
    // ********************************
    // Special mode: free writes, every size code
    // ********************************
    @(posedge clk) special_mode_pin <= 1'b1;
    repeat (4) @(posedge clk);
    wr(EEPROT_IDX, 32'h80);
    rdc(EEPROT_IDX, 32'hFFFFFFFF, 32'h80);
    op(EE_BASE, 1'b0, 1'b0);
    op(EE_BASE, 1'b1, 1'b0);
    for (int s = 0; s < 4; s++) begin
      wr(EEPROT_IDX, s);
      rdc(EEPROT_IDX, 32'hFFFFFFFF, s);
      op(EE_BASE + 24'(EE_SECTOR_BYTES * (s + 1)) - 24'h1, 1'b0, 1'b1);
      op(EE_BASE + 24'(EE_SECTOR_BYTES * (s + 1)), 1'b0, 1'b0);
    end
    wr(STATUS_IDX, 32'h10);
    // ********************************
    // Command object load, launch and lock
    // ********************************
    ahb(1'b1, {24'h0, CMD_WORD0_IDX, 2'b01}, HSIZE_BYTE, {4{8'h06}}, rd);
    ahb(1'b1, {24'h0, CMD_WORD0_IDX, 2'b00}, HSIZE_BYTE, {4{8'h10}}, rd);
    wr(CMD_WORD0_IDX + 6'h1, 32'h0020);
    ahb(1'b0, {24'h0, CMD_WORD0_IDX, 2'b01}, HSIZE_BYTE, 32'h0, rd);
    check(rd & 32'hFFFF, 32'h0610, "word0 byte read");
    check(command_object_array[31:0], 32'h0020_0610, "word layout");
    wr(CMD_INDEX_IDX, 32'h1);
    // The write lands on the edge the task returns at; look once it has settled
    @(negedge clk);
    check({29'h0, command_word_index}, 32'h1, "word index");
    wr(STATUS_IDX, 32'h80);
    @(posedge clk);
    @(negedge clk);
    check(launches, 1, "launch pulse");
    rdc(STATUS_IDX, 32'h80, 32'h00);
    wr(CMD_WORD0_IDX, 32'hFFFF);
    wr(CMD_INDEX_IDX, 32'h5);
    wr(STATUS_IDX, 32'h80);
    rdc(CMD_WORD0_IDX, 32'hFFFF, 32'h0610);
    check({29'h0, command_word_index}, 32'h1, "index locked");
    check(launches, 1, "no relaunch");
    @(posedge clk);
    result_we <= 1'b1;
    result_index <= 3'h2;
    result_data <= 16'hBEEF;
    @(posedge clk) result_we <= 1'b0;
    @(posedge clk) cmd_done <= 1'b1;
    @(posedge clk) cmd_done <= 1'b0;
    rdc(STATUS_IDX, 32'h80, 32'h80);
    rdc(CMD_WORD0_IDX + 6'h2, 32'hFFFF, 32'hBEEF);
    wr(CMD_WORD0_IDX + 6'h5, 32'h1234);
    rdc(CMD_WORD0_IDX + 6'h5, 32'hFFFF, 32'h1234);
    // ********************************
    // Second reset with double faults
    // ********************************
    cfg_prot_fault <= 1'b1;
    cfg_option_fault <= 1'b1;
    cfg_option_byte <= 8'h12;
    do_reset();
    rdc(EEPROT_IDX, 32'hFFFFFFFF, 32'h03);
    rdc(OPTION_IDX, 32'hFFFFFFFF, 32'hFF);
    rdc(STATUS_IDX, 32'h80, 32'h80);
    results();
  end
endmodule
